// ===== dv/fps_ctrl_assertions.sv
`timescale 1ns/1ps
module fps_ctrl_assertions (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Programmer link
  input wire logic       pgm_attach,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       rsp_valid,
  input wire logic       rsp_ack,
  input wire logic       rsp_nak,
  // Self-programming
  input wire logic       spm_wr,
  input wire logic [7:0] spm_wdata,
  input wire logic       halt_exec,
  input wire logic       halt_active,
  input wire logic       self_mode,
  input wire logic       irq_block,
  input wire logic       cpu_run,
  // Status
  input wire logic       prog_mode,
  input wire logic       pins_reset_state,
  input wire logic       pins_halt_state,
  input wire logic [2:0] sec_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Steps
  sequence s_take;
    cmd_valid && pgm_attach && cmd_ready;
  endsequence
  sequence s_halt_go;
    halt_exec && self_mode && !halt_active;
  endsequence

  // ==========================================================================
  // Checks
  rsp_onehot_a: assert property (rsp_valid |-> rsp_ack != rsp_nak)
    else $error("response flags not exclusive");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  take_busy_a: assert property (s_take |=> rsp_valid || !cmd_ready)
    else $error("ready stayed high after a taken command");
  take_answer_a: assert property (s_take |-> ##[1:200] rsp_valid)
    else $error("command got no response");
  prog_entry_a: assert property (s_take |-> ##2 prog_mode)
    else $error("command did not enter programming mode");
  pin_reset_a: assert property (pins_reset_state == prog_mode)
    else $error("pin state differs from programming mode");
  pin_halt_a: assert property (pins_halt_state == self_mode && irq_block == self_mode)
    else $error("halt pins or interrupt block differ from self mode");
  self_key_a: assert property ($rose(self_mode) |-> $past(spm_wr, 2) && $past(spm_wdata[0], 2))
    else $error("self mode entered without a mode write");
  halt_go_a: assert property (s_halt_go |=> halt_active ##1 !cpu_run)
    else $error("halt did not start the operation");
  halt_gate_a: assert property (!self_mode && !halt_active |=> !halt_active)
    else $error("halt operation outside self mode");
  flags_keep_a: assert property (sec_flags[0] |=> (sec_flags & $past(sec_flags)) == $past(sec_flags))
    else $error("protection cleared after chip protect");
  flags_self_a: assert property (self_mode |=> $stable(sec_flags))
    else $error("protection changed in self mode");
endmodule : fps_ctrl_assertions

bind fps_ctrl fps_ctrl_assertions u_chk (.ref_clk, .rst, .pgm_attach, .cmd_valid, .cmd_ready,
  .rsp_valid, .rsp_ack, .rsp_nak, .spm_wr, .spm_wdata, .halt_exec, .halt_active, .self_mode,
  .irq_block, .cpu_run, .prog_mode, .pins_reset_state, .pins_halt_state, .sec_flags);

// ===== dv/fps_ctrl_tb.sv
`timescale 1ns/1ps
module fps_ctrl_tb;
  import fps_pkg::*;
  `include "fps_cfg.svh"
  localparam logic [1:0] ACK = 2'h2;
  localparam logic [1:0] NAK = 2'h1;
  logic        ref_clk, rst, spm_wr, halt_exec, pgm_attach, cmd_valid, cmd_ready;
  logic        rsp_valid, rsp_ack, rsp_nak, halt_active, sp_fail, self_mode, irq_block;
  logic        cpu_run, prog_mode, pins_reset_state, pins_halt_state;
  logic [1:0]  sp_cmd, r;
  logic [2:0]  cmd_code, sec_flags;
  logic [5:0]  cmd_lo, cmd_hi, sp_addr, rd_addr;
  logic [7:0]  cmd_data, spm_wdata, sp_data, rd_data;
  logic [15:0] rsp_sum;
  int          n_errors, total_checks;

  fps_ctrl dut (.ref_clk, .rst, .pgm_attach, .cmd_valid, .cmd_code, .cmd_lo, .cmd_hi,
    .cmd_data, .cmd_ready, .rsp_valid, .rsp_ack, .rsp_nak, .rsp_sum, .spm_wr, .spm_wdata,
    .halt_exec, .sp_cmd, .sp_addr, .sp_data, .halt_active, .sp_fail, .self_mode, .irq_block,
    .cpu_run, .rd_addr, .rd_data, .prog_mode, .pins_reset_state, .pins_halt_state, .sec_flags);
  fps_pgm_model pgm (.ref_clk, .cmd_ready, .rsp_valid, .rsp_ack, .rsp_nak, .pgm_attach,
    .cmd_valid, .cmd_code, .cmd_lo, .cmd_hi, .cmd_data);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Tasks
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask : chk

  task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
      if (g === 2'h3) stop_test();
    end
  endtask : chk_rsp

  task automatic cmd(input logic [2:0] c, input logic [5:0] l, input logic [5:0] h,
                     input logic [7:0] d, input logic [1:0] e);
    pgm.send(c, l, h, d, r);
    chk_rsp(r, e);
  endtask : cmd

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge ref_clk) rd_addr = a;
    @(negedge ref_clk);
    chk(rd_data, e);
  endtask : rd

  // Waits for halt_active (w=1) or prog_mode (w=0) to drop.
  task automatic wait_lo(input int w);
    for (int i = 0; i < 400; i++) begin
      @(negedge ref_clk);
      if ((w ? halt_active : prog_mode) === 1'b0) return;
    end
    n_errors++;
    stop_test();
  endtask : wait_lo

  task automatic reenter();
    pgm.detach();
    wait_lo(0);
  endtask : reenter

  task automatic spw(input logic [7:0] d);
    @(negedge ref_clk) {spm_wr, spm_wdata} = {1'b1, d};
    @(negedge ref_clk) spm_wr = 1'b0;
    // The mode outputs follow the internal mode one cycle later.
    @(negedge ref_clk);
  endtask : spw

  task automatic halt(input logic [1:0] c, input logic [5:0] a, input logic [7:0] d,
                      input logic e);
    @(negedge ref_clk) {halt_exec, sp_cmd, sp_addr, sp_data} = {1'b1, c, a, d};
    @(negedge ref_clk) halt_exec = 1'b0;
    chk(halt_active, e);
    wait_lo(1);
  endtask : halt

  // ==========================================================================
  // Sequence
  initial begin
    {spm_wr, spm_wdata, halt_exec, sp_cmd, sp_addr, sp_data, rd_addr} = '0;
    n_errors = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(sec_flags, 16'h0);
    chk(cpu_run, 16'h1);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    cmd(`FPS_CMD_BLANK_CHECK, 6'h00, 6'h3F, 8'h00, ACK);
    chk({prog_mode, pins_reset_state}, 16'h3);
    cmd(`FPS_CMD_WRITE, 6'h00, 6'h03, 8'h3C, ACK);
    cmd(`FPS_CMD_WRITE, 6'h10, 6'h11, 8'h5A, ACK);
    cmd(`FPS_CMD_CHECKSUM, 6'h00, 6'h03, 8'h00, ACK);
    chk(rsp_sum, 16'h00F0);
    cmd(`FPS_CMD_BLANK_CHECK, 6'h00, 6'h3F, 8'h00, NAK);
    cmd(`FPS_CMD_WRITE, 6'h10, 6'h10, 8'hC3, NAK);
    cmd(`FPS_CMD_BLOCK_ERASE, 6'h00, 6'h00, 8'h00, ACK);
    rd(6'h00, `FPS_BLANK);
    rd(6'h10, 8'h42);
    cmd(3'h0, 6'h00, 6'h00, 8'h00, NAK);
    cmd(3'h7, 6'h00, 6'h00, 8'h00, NAK);
    cmd(`FPS_CMD_SECURITY, 6'h00, 6'h00, 8'h02, ACK);
    cmd(`FPS_CMD_BLOCK_ERASE, 6'h20, 6'h20, 8'h00, ACK);
    reenter();
    cmd(`FPS_CMD_BLOCK_ERASE, 6'h20, 6'h20, 8'h00, NAK);
    cmd(`FPS_CMD_WRITE, 6'h21, 6'h21, 8'hF0, ACK);
    cmd(`FPS_CMD_SECURITY, 6'h00, 6'h00, 8'h04, ACK);
    chk(sec_flags, 16'h6);
    reenter();
    cmd(`FPS_CMD_WRITE, 6'h22, 6'h22, 8'h00, NAK);
    cmd(`FPS_CMD_BLOCK_ERASE, 6'h20, 6'h20, 8'h00, NAK);
    cmd(`FPS_CMD_CHIP_ERASE, 6'h00, 6'h00, 8'h00, ACK);
    chk(sec_flags, 16'h0);
    cmd(`FPS_CMD_BLANK_CHECK, 6'h00, 6'h3F, 8'h00, ACK);
    cmd(`FPS_CMD_SECURITY, 6'h00, 6'h00, 8'h01, ACK);
    reenter();
    cmd(`FPS_CMD_CHIP_ERASE, 6'h00, 6'h00, 8'h00, NAK);
    cmd(`FPS_CMD_BLOCK_ERASE, 6'h00, 6'h00, 8'h00, NAK);
    cmd(`FPS_CMD_WRITE, 6'h20, 6'h20, 8'h00, ACK);
    reenter();
    spw(8'h01);
    chk(self_mode, 16'h0);
    spw(`FPS_UNLOCK_KEY);
    spw(8'h01);
    chk({self_mode, irq_block, pins_halt_state, cpu_run}, 16'hF);
    halt(`FPS_SP_WRITE, 6'h30, 8'h12, 1'b1);
    chk(sp_fail, 16'h0);
    rd(6'h30, 8'h12);
    halt(`FPS_SP_ERASE, 6'h30, 8'h00, 1'b1);
    rd(6'h30, `FPS_BLANK);
    halt(`FPS_SP_BLANK, 6'h20, 8'h00, 1'b1);
    chk(sp_fail, 16'h1);
    chk(sec_flags, 16'h1);
    spw(`FPS_UNLOCK_KEY);
    spw(8'h00);
    chk(self_mode, 16'h0);
    halt(`FPS_SP_WRITE, 6'h31, 8'h00, 1'b0);
    stop_test();
  end
endmodule : fps_ctrl_tb

// ===== dv/fps_pgm_model.sv
`timescale 1ns/1ps
module fps_pgm_model (
  // Clock and device answers
  input wire logic  ref_clk,
  input wire logic  cmd_ready,
  input wire logic  rsp_valid,
  input wire logic  rsp_ack,
  input wire logic  rsp_nak,
  // Command frame
  output logic       pgm_attach,
  output logic       cmd_valid,
  output logic [2:0] cmd_code,
  output logic [5:0] cmd_lo,
  output logic [5:0] cmd_hi,
  output logic [7:0] cmd_data
);
  initial begin
    {pgm_attach, cmd_valid, cmd_code, cmd_lo, cmd_hi, cmd_data} = '0;
  end

  // Only this side originates commands; r is {ack, nak}, 3 when no answer came.
  task automatic send(input logic [2:0] c, input logic [5:0] l, input logic [5:0] h,
                      input logic [7:0] d, output logic [1:0] r);
    r = 2'h3;
    @(negedge ref_clk);
    {pgm_attach, cmd_valid, cmd_code, cmd_lo, cmd_hi, cmd_data} = {2'h3, c, l, h, d};
    for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    // Released fields show garbage rather than the last value.
    {cmd_code, cmd_lo, cmd_hi, cmd_data} = ~{c, l, h, d};
    // The one-cycle response is looked at on falling edges, where it stands settled.
    for (int i = 0; i < 300 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
    if (rsp_valid === 1'b1) r = {rsp_ack, rsp_nak};
  endtask : send

  task automatic detach();
    @(negedge ref_clk);
    pgm_attach = 1'b0;
  endtask : detach
endmodule : fps_pgm_model

// ===== hdl/fps_cfg.svh
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

// ==========================================================================
// Programmer command codes
`define FPS_CMD_CHIP_ERASE  3'h1
`define FPS_CMD_BLOCK_ERASE 3'h2
`define FPS_CMD_WRITE       3'h3
`define FPS_CMD_CHECKSUM    3'h4
`define FPS_CMD_BLANK_CHECK 3'h5
`define FPS_CMD_SECURITY    3'h6

// ==========================================================================
// Security flag positions and shipped value
`define FPS_SEC_CHIP   0
`define FPS_SEC_BLOCK  1
`define FPS_SEC_WRITE  2
`define FPS_SEC_W      3
`define FPS_SEC_RESET  3'h0

// ==========================================================================
// Flash contents
`define FPS_BLANK      8'hFF

// ==========================================================================
// Self-programming unlock sequence and operation codes
`define FPS_UNLOCK_KEY 8'hA5
`define FPS_MODE_BIT   0
`define FPS_SP_WRITE   2'h1
`define FPS_SP_ERASE   2'h2
`define FPS_SP_BLANK   2'h3

`endif

// ===== hdl/fps_ctrl.sv
`timescale 1ns/1ps
module fps_ctrl #(
  parameter int AW = 6,
  parameter int BW = 4
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Programmer link, frames already decoded from the serial line
  input  wire logic          pgm_attach,
  input  wire logic          cmd_valid,
  input  wire logic [2:0]    cmd_code,
  input  wire logic [AW-1:0] cmd_lo,
  input  wire logic [AW-1:0] cmd_hi,
  input  wire logic [7:0]    cmd_data,
  output logic               cmd_ready,
  output logic               rsp_valid,
  output logic               rsp_ack,
  output logic               rsp_nak,
  output logic [15:0]        rsp_sum,
  // Self-programming control from the CPU
  input  wire logic          spm_wr,
  input  wire logic [7:0]    spm_wdata,
  input  wire logic          halt_exec,
  input  wire logic [1:0]    sp_cmd,
  input  wire logic [AW-1:0] sp_addr,
  input  wire logic [7:0]    sp_data,
  output logic               halt_active,
  output logic               sp_fail,
  output logic               self_mode,
  output logic               irq_block,
  output logic               cpu_run,
  // Ordinary data reads
  input  wire logic [AW-1:0] rd_addr,
  output logic [7:0]         rd_data,
  // Mode, pin state and protection status
  output logic               prog_mode,
  output logic               pins_reset_state,
  output logic               pins_halt_state,
  output logic [2:0]         sec_flags
);
  import fps_pkg::*;
  `include "fps_cfg.svh"

  if (AW < 2 || AW > 12 || BW < 1 || BW >= AW) begin : g_bad_cfg
    $error("fps_ctrl: unsupported AW or BW");
  end

  // ========================================================================
  // Helpers
  function automatic logic [AW-1:0] blk_lo(input logic [AW-1:0] a);
    blk_lo = {a[AW-1:BW], {BW{1'b0}}};
  endfunction : blk_lo

  function automatic logic [AW-1:0] blk_hi(input logic [AW-1:0] a);
    blk_hi = {a[AW-1:BW], {BW{1'b1}}};
  endfunction : blk_hi

  // Whether a command is forbidden by the given protection flags.
  function automatic logic refused(input logic [2:0] c,
                                   input logic [`FPS_SEC_W-1:0] f);
    refused = 1'b0;
    if (c == `FPS_CMD_CHIP_ERASE) begin
      refused = f[`FPS_SEC_CHIP];
    end else if (c == `FPS_CMD_BLOCK_ERASE) begin
      refused = f[`FPS_SEC_CHIP] | f[`FPS_SEC_BLOCK] | f[`FPS_SEC_WRITE];
    end else if (c == `FPS_CMD_WRITE) begin
      refused = f[`FPS_SEC_WRITE];
    end
  endfunction : refused

  function automatic logic legal(input logic [2:0] c);
    legal = (c == `FPS_CMD_CHIP_ERASE) || (c == `FPS_CMD_BLOCK_ERASE) ||
            (c == `FPS_CMD_WRITE) || (c == `FPS_CMD_CHECKSUM) ||
            (c == `FPS_CMD_BLANK_CHECK) || (c == `FPS_CMD_SECURITY);
  endfunction : legal

  // ========================================================================
  // State
  fps_mode_t               mode_q;
  fps_seq_t                seq_q;
  logic [`FPS_SEC_W-1:0]   sec_q;
  logic [`FPS_SEC_W-1:0]   sess_q;
  logic [`FPS_SEC_W-1:0]   eff_sec;
  logic                    unlock_q;
  logic [2:0]              code_q;
  logic                    start_q;
  fps_op_t                 op_q;
  logic [AW-1:0]           lo_q;
  logic [AW-1:0]           hi_q;
  logic [7:0]              wdata_q;
  logic                    ready_q;
  logic                    rsp_valid_q;
  logic                    rsp_ack_q;
  logic                    rsp_nak_q;
  logic [15:0]             rsp_sum_q;
  logic                    halt_q;
  logic                    sp_fail_q;
  logic                    take_cmd;
  logic                    take_halt;
  logic                    enter_prog;

  fps_flash_if #(.AW(AW)) fl ();

  fps_flash #(.AW(AW)) u_flash (
    .ref_clk (ref_clk),
    .rst     (rst),
    .fl      (fl)
  );

  assign fl.start = start_q;
  assign fl.op    = op_q;
  assign fl.lo    = lo_q;
  assign fl.hi    = hi_q;
  assign fl.wdata = wdata_q;
  assign fl.raddr = rd_addr;

  // A command is only taken from the programmer, never generated here.
  assign enter_prog = (mode_q == FPS_M_NORMAL) && pgm_attach && cmd_valid;
  assign take_cmd   = (seq_q == FPS_S_IDLE) && cmd_valid && pgm_attach &&
                      (mode_q == FPS_M_PROG || enter_prog);
  assign take_halt  = (seq_q == FPS_S_IDLE) && halt_exec &&
                      (mode_q == FPS_M_SELF);
  // On the entry cycle the stored flags apply directly, else the session copy.
  assign eff_sec    = enter_prog ? sec_q : sess_q;

  // ========================================================================
  // Operating mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q   <= FPS_M_NORMAL;
      unlock_q <= 1'b0;
    end else begin
      case (mode_q)
        FPS_M_NORMAL: begin
          if (enter_prog) begin
            mode_q <= FPS_M_PROG;
          end else if (spm_wr) begin
            unlock_q <= (spm_wdata == `FPS_UNLOCK_KEY);
            if (unlock_q && spm_wdata[`FPS_MODE_BIT]) begin
              mode_q <= FPS_M_SELF;
            end
          end
        end
        FPS_M_PROG: begin
          unlock_q <= 1'b0;
          if (!pgm_attach && seq_q == FPS_S_IDLE) begin
            mode_q <= FPS_M_NORMAL;
          end
        end
        FPS_M_SELF: begin
          if (spm_wr && seq_q == FPS_S_IDLE) begin
            unlock_q <= (spm_wdata == `FPS_UNLOCK_KEY);
            if (unlock_q && !spm_wdata[`FPS_MODE_BIT]) begin
              mode_q <= FPS_M_NORMAL;
            end
          end
        end
        default: mode_q <= FPS_M_NORMAL;
      endcase
    end
  end

  // ========================================================================
  // Protection flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sec_q <= `FPS_SEC_RESET;
    end else if (take_cmd && cmd_code == `FPS_CMD_SECURITY && cmd_lo <= cmd_hi) begin
      sec_q <= sec_q | cmd_data[`FPS_SEC_W-1:0];
    end else if (seq_q == FPS_S_PGM && fl.done && fl.ok &&
                 code_q == `FPS_CMD_CHIP_ERASE && !sec_q[`FPS_SEC_CHIP]) begin
      sec_q[`FPS_SEC_BLOCK] <= 1'b0;
      sec_q[`FPS_SEC_WRITE] <= 1'b0;
    end
  end

  // Session copy captured only at programming mode entry.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sess_q <= `FPS_SEC_RESET;
    end else if (enter_prog) begin
      sess_q <= sec_q;
    end
  end

  // ========================================================================
  // Command and halt sequencing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seq_q   <= FPS_S_IDLE;
      ready_q <= 1'b0;
      start_q <= 1'b0;
      code_q  <= 3'h0;
      op_q    <= FPS_OP_SUM;
      lo_q    <= '0;
      hi_q    <= '0;
      wdata_q <= 8'h00;
    end else begin
      start_q <= 1'b0;
      case (seq_q)
        FPS_S_IDLE: begin
          ready_q <= 1'b1;
          if (take_cmd) begin
            code_q <= cmd_code;
            if (legal(cmd_code) && !refused(cmd_code, eff_sec) &&
                cmd_code != `FPS_CMD_SECURITY && cmd_lo <= cmd_hi) begin
              seq_q   <= FPS_S_PGM;
              ready_q <= 1'b0;
              start_q <= 1'b1;
              wdata_q <= cmd_data;
              lo_q    <= cmd_lo;
              hi_q    <= cmd_hi;
              if (cmd_code == `FPS_CMD_CHIP_ERASE) begin
                op_q <= FPS_OP_ERASE;
                lo_q <= '0;
                hi_q <= '1;
              end else if (cmd_code == `FPS_CMD_BLOCK_ERASE) begin
                op_q <= FPS_OP_ERASE;
                lo_q <= blk_lo(cmd_lo);
                hi_q <= blk_hi(cmd_lo);
              end else if (cmd_code == `FPS_CMD_WRITE) begin
                op_q <= FPS_OP_WRITE;
              end else if (cmd_code == `FPS_CMD_CHECKSUM) begin
                op_q <= FPS_OP_SUM;
              end else begin
                op_q <= FPS_OP_BLANK;
                lo_q <= '0;
                hi_q <= '1;
              end
            end
          end else if (take_halt) begin
            // Self-programming ignores the protection flags entirely.
            seq_q   <= FPS_S_SELF;
            ready_q <= 1'b0;
            start_q <= 1'b1;
            wdata_q <= sp_data;
            lo_q    <= sp_addr;
            hi_q    <= sp_addr;
            if (sp_cmd == `FPS_SP_WRITE) begin
              op_q <= FPS_OP_WRITE;
            end else if (sp_cmd == `FPS_SP_ERASE) begin
              op_q <= FPS_OP_ERASE;
              lo_q <= blk_lo(sp_addr);
              hi_q <= blk_hi(sp_addr);
            end else begin
              op_q <= FPS_OP_BLANK;
              lo_q <= blk_lo(sp_addr);
              hi_q <= blk_hi(sp_addr);
            end
          end
        end
        FPS_S_PGM: begin
          if (fl.done) begin
            seq_q   <= FPS_S_IDLE;
            ready_q <= 1'b1;
          end
        end
        FPS_S_SELF: begin
          if (fl.done) begin
            seq_q   <= FPS_S_IDLE;
            ready_q <= 1'b1;
          end
        end
        default: begin
          seq_q   <= FPS_S_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Responses to the programmer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_ack_q   <= 1'b0;
      rsp_nak_q   <= 1'b0;
      rsp_sum_q   <= 16'h0000;
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_ack_q   <= 1'b0;
      rsp_nak_q   <= 1'b0;
      if (take_cmd) begin
        if (!legal(cmd_code) || refused(cmd_code, eff_sec) || cmd_lo > cmd_hi) begin
          rsp_valid_q <= 1'b1;
          rsp_nak_q   <= 1'b1;
        end else if (cmd_code == `FPS_CMD_SECURITY) begin
          rsp_valid_q <= 1'b1;
          rsp_ack_q   <= 1'b1;
        end
      end else if (seq_q == FPS_S_PGM && fl.done) begin
        rsp_valid_q <= 1'b1;
        rsp_ack_q   <= fl.ok;
        rsp_nak_q   <= !fl.ok;
        if (code_q == `FPS_CMD_CHECKSUM) begin
          rsp_sum_q <= fl.sum;
        end
      end
    end
  end

  // ========================================================================
  // Halt and self-programming status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      halt_q    <= 1'b0;
      sp_fail_q <= 1'b0;
    end else if (take_halt) begin
      halt_q    <= 1'b1;
      sp_fail_q <= 1'b0;
    end else if (seq_q == FPS_S_SELF && fl.done) begin
      halt_q    <= 1'b0;
      sp_fail_q <= !fl.ok;
    end
  end

  // ========================================================================
  // Registered outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_mode        <= 1'b0;
      pins_reset_state <= 1'b0;
      pins_halt_state  <= 1'b0;
      self_mode        <= 1'b0;
      irq_block        <= 1'b0;
      cpu_run          <= 1'b1;
    end else begin
      prog_mode        <= (mode_q == FPS_M_PROG);
      pins_reset_state <= (mode_q == FPS_M_PROG);
      pins_halt_state  <= (mode_q == FPS_M_SELF);
      self_mode        <= (mode_q == FPS_M_SELF);
      irq_block        <= (mode_q == FPS_M_SELF);
      cpu_run          <= !halt_q;
    end
  end

  assign cmd_ready   = ready_q;
  assign rsp_valid   = rsp_valid_q;
  assign rsp_ack     = rsp_ack_q;
  assign rsp_nak     = rsp_nak_q;
  assign rsp_sum     = rsp_sum_q;
  assign halt_active = halt_q;
  assign sp_fail     = sp_fail_q;
  assign rd_data     = fl.rdata;
  assign sec_flags   = sec_q;
endmodule : fps_ctrl

// ===== hdl/fps_flash.sv
`timescale 1ns/1ps
module fps_flash #(
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Controller side
  fps_flash_if.eng fl
);
  import fps_pkg::*;
  `include "fps_cfg.svh"

  localparam int DEPTH = 1 << AW;

  fps_eng_t      st_q;
  logic [AW-1:0] cur_q;
  logic [7:0]    mem_q [DEPTH];
  logic          ok_q;
  logic [15:0]   sum_q;
  logic [7:0]    rdata_q;
  logic          last;

  assign last = (cur_q == fl.hi);

  // ========================================================================
  // Sequencing: one byte per cycle from lo to hi, writes get a second pass.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q  <= FPS_E_IDLE;
      cur_q <= '0;
    end else begin
      case (st_q)
        FPS_E_IDLE: begin
          if (fl.start) begin
            st_q  <= FPS_E_RUN;
            cur_q <= fl.lo;
          end
        end
        FPS_E_RUN: begin
          if (last) begin
            cur_q <= fl.lo;
            st_q  <= (fl.op == FPS_OP_WRITE) ? FPS_E_VERIFY : FPS_E_DONE;
          end else begin
            cur_q <= cur_q + 1'b1;
          end
        end
        FPS_E_VERIFY: begin
          if (last) begin
            st_q <= FPS_E_DONE;
          end else begin
            cur_q <= cur_q + 1'b1;
          end
        end
        FPS_E_DONE: st_q <= FPS_E_IDLE;
        default:    st_q <= FPS_E_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Array: erase sets bytes blank, programming can only clear bits.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= `FPS_BLANK;
      end
    end else if (st_q == FPS_E_RUN) begin
      if (fl.op == FPS_OP_ERASE) begin
        mem_q[cur_q] <= `FPS_BLANK;
      end else if (fl.op == FPS_OP_WRITE) begin
        mem_q[cur_q] <= mem_q[cur_q] & fl.wdata;
      end
    end
  end

  // ========================================================================
  // Results: verify and blank flags, running checksum.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ok_q  <= 1'b0;
      sum_q <= 16'h0000;
    end else if (st_q == FPS_E_IDLE && fl.start) begin
      ok_q  <= 1'b1;
      sum_q <= 16'h0000;
    end else if (st_q == FPS_E_RUN) begin
      if (fl.op == FPS_OP_BLANK && mem_q[cur_q] != `FPS_BLANK) begin
        ok_q <= 1'b0;
      end
      if (fl.op == FPS_OP_SUM) begin
        sum_q <= sum_q + {8'h00, mem_q[cur_q]};
      end
    end else if (st_q == FPS_E_VERIFY && mem_q[cur_q] != fl.wdata) begin
      ok_q <= 1'b0;
    end
  end

  // Plain read port for ordinary data moves.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_q[fl.raddr];
    end
  end

  assign fl.done  = (st_q == FPS_E_DONE);
  assign fl.ok    = ok_q;
  assign fl.sum   = sum_q;
  assign fl.rdata = rdata_q;
endmodule : fps_flash

// ===== hdl/fps_flash_if.sv
`timescale 1ns/1ps
interface fps_flash_if #(parameter int AW = 6);
  import fps_pkg::*;
  logic          start;
  fps_op_t       op;
  logic [AW-1:0] lo;
  logic [AW-1:0] hi;
  logic [7:0]    wdata;
  logic          done;
  logic          ok;
  logic [15:0]   sum;
  logic [AW-1:0] raddr;
  logic [7:0]    rdata;

  modport ctl (output start, op, lo, hi, wdata, raddr, input done, ok, sum, rdata);
  modport eng (input start, op, lo, hi, wdata, raddr, output done, ok, sum, rdata);
endinterface : fps_flash_if

// ===== hdl/fps_pkg.sv
package fps_pkg;
  `include "fps_cfg.svh"

  typedef enum logic [2:0] {
    FPS_M_NORMAL = 3'b001,
    FPS_M_PROG   = 3'b010,
    FPS_M_SELF   = 3'b100
  } fps_mode_t;

  typedef enum logic [2:0] {
    FPS_S_IDLE = 3'b001,
    FPS_S_PGM  = 3'b010,
    FPS_S_SELF = 3'b100
  } fps_seq_t;

  typedef enum logic [3:0] {
    FPS_E_IDLE   = 4'b0001,
    FPS_E_RUN    = 4'b0010,
    FPS_E_VERIFY = 4'b0100,
    FPS_E_DONE   = 4'b1000
  } fps_eng_t;

  typedef enum logic [1:0] {
    FPS_OP_ERASE = 2'h0,
    FPS_OP_WRITE = 2'h1,
    FPS_OP_SUM   = 2'h2,
    FPS_OP_BLANK = 2'h3
  } fps_op_t;
endpackage : fps_pkg
